// ==== hdl/urs_consts.svh ====
// constants for the receive line-status and special-character block
// assumes one 250 MHz system clock and a byte-wide register port
//
// Notes on behaviour
// [R01] parity, overrun and timeout reach line summary only when enabled
// [R02] line flags belong to last popped character; reads never clear them
// [R03] top line-status bit follows the filtered clear-to-send pin level
// [R04] noise during a character marks that character
// [R05] long low line pushes a zero character marked as break
// [R06] bad stop bit marks the character with a framing error
// [R07] parity mismatch per character; in nine-bit mode carries the ninth bit
// [R08] character into full fifo sets overrun and is dropped
// [R09] stale-data flag after programmed wait; restarts on push or pop; zero disables
// [R10] each of six line flags feeds summary bit zero under its enable
// [R11] six special enables gate their flags into summary bit one
// [R12] address character in nine-bit mode sets the address flag
// [R13] detected break sets the special break flag
// [R14] resume and pause characters flag only while detection is enabled
// [R15] reading special flags returns them then clears all
// [R16] summary bit zero sets on enabled line flag, clears on summary read
// [R17] summary bit one sets on enabled special event, clears on summary read
// [R18] noise when oversamples inside one bit period disagree
`ifndef URS_CONSTS_SVH
`define URS_CONSTS_SVH
`define URS_A_PORT 4'h0
`define URS_A_SUM 4'h2
`define URS_A_LINE_IEN 4'h3
`define URS_A_LINE 4'h4
`define URS_A_SCIE 4'h5
`define URS_A_SCF 4'h6
`define URS_A_STIE 4'h7
`define URS_A_MODE 4'ha
`define URS_A_TMO 4'hb
`define URS_A_XON1 4'hc
`define URS_B_MDROP 6
`define URS_B_SPCHR 4
`define URS_RST_BYTE 8'h00
`define URS_RST_CTS 1'b1
`define URS_CLK_NS 4
`define URS_TMO_UNIT_NS 64
`define URS_TMO_UNIT_CYC ((`URS_TMO_UNIT_NS + `URS_CLK_NS - 1) / `URS_CLK_NS)
`define URS_FIFO_AW 4
`endif

// ==== hdl/urs_pkg.sv ====
// types shared by the receive status block
// assumes nothing outside itself
package urs_pkg;
  typedef logic [7:0] urs_byte_t;
  typedef struct packed {
    logic noise;
    logic brk;
    logic frame;
    logic par;
    urs_byte_t data;
  } urs_entry_s;
endpackage : urs_pkg

// ==== hdl/urs_rx_status.sv ====
// receive fifo with per-character line status and special-character flags
// assumes a bit/character receiver on the same clock and a host register port
`timescale 1ns/1ps
`default_nettype none
`include "urs_consts.svh"
module urs_rx_status
  import urs_pkg::*;
(
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  // host register port
  input wire logic [3:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  // pin
  input wire logic CTS_N,
  // receiver
  input wire logic RX_BIT_STROBE,
  input wire logic [2:0] RX_BIT_SAMPLES,
  input wire logic RX_CHAR_VALID,
  input wire logic [7:0] RX_CHAR_DATA,
  input wire logic RX_NINTH_BIT,
  input wire logic RX_PARITY_BAD,
  input wire logic RX_STOP_BAD,
  input wire logic RX_BREAK,
  // summary
  output logic LINE_ERR_SUMMARY,
  output logic SPECIAL_SUMMARY
);
  localparam int DEPTH = 1 << `URS_FIFO_AW;
  localparam logic [3:0] UNIT_MAX = 4'(`URS_TMO_UNIT_CYC - 1);

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);

  // ----------------------------------------------------------
  // register state
  // ----------------------------------------------------------
  logic [5:0] lsrie, next_lsrie, scie, next_scie;
  logic [5:0] stie, next_stie, scf, next_scf, scf_set;
  logic mdrop, next_mdrop, spchr, next_spchr;
  urs_byte_t tmo_set, next_tmo_set;
  urs_byte_t xch [4];
  urs_byte_t next_xch [4];
  logic [7:0] next_rdata;
  logic [1:0] summ, next_summ;
  logic rd_port, rd_sum, rd_scf;

  // ----------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------
  logic cts_s1, cts_s2, cts_s3, cts_lvl, next_cts_lvl;
  // a change counts only once stages two and three agree
  always_comb begin
    next_cts_lvl = (cts_s2 == cts_s3) ? cts_s3 : cts_lvl;
  end
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      cts_s1 <= `URS_RST_CTS;
      cts_s2 <= `URS_RST_CTS;
      cts_s3 <= `URS_RST_CTS;
      cts_lvl <= `URS_RST_CTS;
    end else begin
      cts_s1 <= CTS_N;
      cts_s2 <= cts_s1;
      cts_s3 <= cts_s2;
      cts_lvl <= next_cts_lvl; // R03
    end
  end
  a_cts_follow: assert property ((cts_s2 == cts_s3) |=> cts_lvl == $past(cts_s3)) // R03
    else $error("cts level not followed");

  // ----------------------------------------------------------
  // receive fifo and per-character status
  // ----------------------------------------------------------
  urs_entry_s mem [DEPTH];
  urs_entry_s entry, head;
  logic [`URS_FIFO_AW-1:0] wp, rp, next_wp, next_rp;
  logic [`URS_FIFO_AW:0] count, next_count;
  logic noise_acc, next_noise_acc, mixed, full, push, pop;
  logic [3:0] lflags, next_lflags;
  logic ovr, next_ovr;

  assign head = mem[rp];
  // noise is any disagreement of oversamples inside a bit period
  always_comb begin
    mixed = RX_BIT_STROBE & ~(&RX_BIT_SAMPLES | ~|RX_BIT_SAMPLES); // R18
    full = (count == (`URS_FIFO_AW+1)'(DEPTH));
    push = RX_CHAR_VALID & ~full; // R08
    pop = rd_port & (count != '0);
    entry.noise = noise_acc | mixed; // R04
    entry.brk = RX_BREAK; // R05
    entry.frame = RX_STOP_BAD; // R06
    // nine-bit mode skips parity and reports the address bit
    entry.par = mdrop ? RX_NINTH_BIT : RX_PARITY_BAD; // R07
    entry.data = RX_BREAK ? `URS_RST_BYTE : RX_CHAR_DATA; // R05
    next_noise_acc = RX_CHAR_VALID ? 1'b0 : (noise_acc | mixed);
    next_wp = push ? wp + 1'b1 : wp;
    next_rp = pop ? rp + 1'b1 : rp;
    next_count = count + (`URS_FIFO_AW+1)'(push) - (`URS_FIFO_AW+1)'(pop);
    // popped character's flags replace the old ones
    next_lflags = pop ? {head.noise, head.brk, head.frame, head.par} : lflags; // R02
    // overrun survives pops of erroneous characters; set wins over clear
    next_ovr = (RX_CHAR_VALID & full) // R08
             | (ovr & ~(pop & ~(head.noise | head.brk | head.frame | head.par))); // R02
  end
  always_ff @(posedge CLK_SYS) begin
    if (push) begin
      mem[wp] <= entry;
    end
  end
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      wp <= '0;
      rp <= '0;
      count <= '0;
      noise_acc <= 1'b0;
      lflags <= '0;
      ovr <= 1'b0;
    end else begin
      wp <= next_wp;
      rp <= next_rp;
      count <= next_count;
      noise_acc <= next_noise_acc;
      lflags <= next_lflags;
      ovr <= next_ovr;
    end
  end
  sequence s_pop;
    pop;
  endsequence
  a_pop_flags: assert property (s_pop |=> lflags == $past({head.noise, head.brk, head.frame, head.par})) // R02
    else $error("line flags not loaded on pop");
  a_status_keep: assert property ((REG_RD && REG_ADDR == `URS_A_LINE) |=> lflags == $past(lflags)) // R02
    else $error("line status changed by its read");
  a_ovr_set: assert property ((RX_CHAR_VALID && full) |=> ovr) // R08
    else $error("overrun not flagged");
  a_full_keep: assert property ((RX_CHAR_VALID && full && !pop) |=> count == $past(count)) // R08
    else $error("full fifo accepted a character");

  // ----------------------------------------------------------
  // stale-data timeout
  // ----------------------------------------------------------
  logic [3:0] unit, next_unit;
  urs_byte_t tmo_cnt, next_tmo_cnt;
  logic tmo, next_tmo;
  // any push or pop restarts the wait; zero setting disables it
  always_comb begin
    next_unit = (push | pop | unit == UNIT_MAX) ? 4'h0 : unit + 4'h1;
    next_tmo_cnt = tmo_cnt;
    if (push | pop) begin
      next_tmo_cnt = 8'h00; // R09
    end else if (unit == UNIT_MAX && tmo_cnt != 8'hff) begin
      next_tmo_cnt = tmo_cnt + 8'h01;
    end
    next_tmo = ~(push | pop) & (tmo_set != 8'h00) & (count != '0)
             & (tmo | (tmo_cnt >= tmo_set)); // R09
  end
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      unit <= 4'h0;
      tmo_cnt <= 8'h00;
      tmo <= 1'b0;
    end else begin
      unit <= next_unit;
      tmo_cnt <= next_tmo_cnt;
      tmo <= next_tmo;
    end
  end
  a_tmo_off: assert property ((tmo_set == 8'h00) |=> !tmo) // R09
    else $error("timeout set while disabled");

  // ----------------------------------------------------------
  // special characters and summary
  // ----------------------------------------------------------
  logic [5:0] lsr_err, lmask, lmask_q, smask, smask_q;
  logic any_x;
  always_comb begin
    any_x = RX_CHAR_VALID & ~RX_BREAK & spchr; // R14
    scf_set[5] = RX_CHAR_VALID & mdrop & RX_NINTH_BIT; // R12
    scf_set[4] = RX_CHAR_VALID & RX_BREAK; // R13
    for (int i = 0; i < 4; i++) begin
      scf_set[i] = any_x & (RX_CHAR_DATA == xch[i]); // R14
    end
    // a read clears everything, but events of the same cycle survive
    next_scf = (rd_scf ? 6'h00 : scf) | scf_set; // R15
    lsr_err = {lflags, ovr, tmo};
    lmask = lsr_err & lsrie; // R01 R10
    smask = scf & scie; // R11
    // edge detection keeps a persisting flag from re-raising after a read
    next_summ[0] = (rd_sum ? 1'b0 : summ[0]) | (|(lmask & ~lmask_q)); // R16
    next_summ[1] = (rd_sum ? 1'b0 : summ[1]) | (|(smask & ~smask_q)); // R17
  end
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      scf <= '0;
      summ <= '0;
      lmask_q <= '0;
      smask_q <= '0;
    end else begin
      scf <= next_scf;
      summ <= next_summ;
      lmask_q <= lmask;
      smask_q <= smask;
    end
  end
  assign LINE_ERR_SUMMARY = summ[0];
  assign SPECIAL_SUMMARY = summ[1];
  a_scf_clear: assert property ((rd_scf && scf_set == 6'h00) |=> scf == 6'h00) // R15
    else $error("special flags not cleared by read");
  a_brk_flag: assert property ((RX_CHAR_VALID && RX_BREAK) |=> scf[4]) // R13
    else $error("break flag missing");
  a_x_gate: assert property ((RX_CHAR_VALID && !spchr && !rd_scf) |=> scf[3:0] == $past(scf[3:0])) // R14
    else $error("special char flagged while detection off");
  a_sum_line: assert property (((lmask & ~lmask_q) != 6'h00) |=> summ[0]) // R16
    else $error("line summary not set");
  a_sum_spec: assert property (((smask & ~smask_q) != 6'h00) |=> summ[1]) // R17
    else $error("special summary not set");
  a_sum_gate: assert property ((lsrie == 6'h00 && !rd_sum) |=> summ[0] == $past(summ[0])) // R10
    else $error("line summary set with enables off");

  // ----------------------------------------------------------
  // register port
  // ----------------------------------------------------------
  always_comb begin
    rd_port = REG_RD & (REG_ADDR == `URS_A_PORT);
    rd_sum = REG_RD & (REG_ADDR == `URS_A_SUM);
    rd_scf = REG_RD & (REG_ADDR == `URS_A_SCF);
    next_lsrie = lsrie;
    next_scie = scie;
    next_stie = stie;
    next_mdrop = mdrop;
    next_spchr = spchr;
    next_tmo_set = tmo_set;
    next_xch = xch;
    if (REG_WR) begin
      if (REG_ADDR == `URS_A_LINE_IEN) begin
        next_lsrie = REG_WDATA[5:0];
      end else if (REG_ADDR == `URS_A_SCIE) begin
        next_scie = REG_WDATA[5:0]; // R11
      end else if (REG_ADDR == `URS_A_STIE) begin
        next_stie = REG_WDATA[5:0];
      end else if (REG_ADDR == `URS_A_MODE) begin
        next_mdrop = REG_WDATA[`URS_B_MDROP];
        next_spchr = REG_WDATA[`URS_B_SPCHR];
      end else if (REG_ADDR == `URS_A_TMO) begin
        next_tmo_set = REG_WDATA;
      end else if (REG_ADDR >= `URS_A_XON1) begin
        next_xch[REG_ADDR[1:0]] = REG_WDATA;
      end
    end
    next_rdata = REG_RDATA;
    if (REG_RD) begin
      next_rdata = 8'h00;
      if (REG_ADDR == `URS_A_PORT) begin
        next_rdata = head.data;
      end else if (REG_ADDR == `URS_A_SUM) begin
        next_rdata = {6'h00, summ};
      end else if (REG_ADDR == `URS_A_LINE_IEN) begin
        next_rdata = {2'b00, lsrie};
      end else if (REG_ADDR == `URS_A_LINE) begin
        next_rdata = {cts_lvl, 1'b0, lsr_err}; // R03
      end else if (REG_ADDR == `URS_A_SCIE) begin
        next_rdata = {2'b00, scie};
      end else if (REG_ADDR == `URS_A_SCF) begin
        next_rdata = {2'b00, scf}; // R15
      end else if (REG_ADDR == `URS_A_STIE) begin
        next_rdata = {2'b00, stie[5], 1'b0, stie[3:0]};
      end else if (REG_ADDR == `URS_A_MODE) begin
        next_rdata = {1'b0, mdrop, 1'b0, spchr, 4'h0};
      end else if (REG_ADDR == `URS_A_TMO) begin
        next_rdata = tmo_set;
      end else if (REG_ADDR >= `URS_A_XON1) begin
        next_rdata = xch[REG_ADDR[1:0]];
      end
    end
  end
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      lsrie <= '0;
      scie <= '0;
      stie <= '0;
      mdrop <= 1'b0;
      spchr <= 1'b0;
      tmo_set <= `URS_RST_BYTE;
      xch <= '{default: `URS_RST_BYTE};
      REG_RDATA <= `URS_RST_BYTE;
    end else begin
      lsrie <= next_lsrie;
      scie <= next_scie;
      stie <= next_stie;
      mdrop <= next_mdrop;
      spchr <= next_spchr;
      tmo_set <= next_tmo_set;
      xch <= next_xch;
      REG_RDATA <= next_rdata;
    end
  end
endmodule : urs_rx_status
`default_nettype wire

// ==== test/urs_host_model.sv ====
// host register port model: one read or write per call
// assumes the block samples its strobes on the rising edge
`timescale 1ns/1ps
`default_nettype none
module urs_host_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  output logic [3:0] addr,
  output logic wr_en,
  output logic rd_en,
  output logic [7:0] wdata,
  // high in the cycle the read answer stands
  output logic rd_done
);
  // strobes idle low from time zero so nothing is taken during reset
  initial begin
    {addr, wr_en, rd_en, wdata} = '0;
  end
  // answer is registered, so it is valid one cycle after the read edge
  always_ff @(posedge clk) begin
    rd_done <= rd_en && !rst;
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    {addr, wdata, wr_en} <= {a, d, 1'b1};
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    {addr, rd_en} <= {a, 1'b1};
    @(posedge clk);
    rd_en <= 1'b0;
  endtask : rd
endmodule : urs_host_model
`default_nettype wire

// ==== test/urs_rx_status_tb.sv ====
// self-checking bench for the receive status block
// assumes the host model is compiled before this file
`timescale 1ns/1ps
`default_nettype none
module urs_rx_status_tb;
  logic clk = 0, rst = 1, cts_n = 1, bs = 0, cv = 0, n9 = 0, pb = 0, sb = 0, bk = 0;
  logic [2:0] smp = '0;
  logic [7:0] cd = '0, d, en;
  logic [7:0] ov[17];
  logic [7:0] c[4];
  logic [3:0] wa[5] = '{4'h4, 4'h1, 4'h3, 4'h5, 4'h7};
  logic [7:0] wx[5] = '{8'h80, 8'h00, 8'h3f, 8'h3f, 8'h2f};
  logic [11:0] q[$];
  wire [3:0] ra;
  wire rw, rr, done, les, sps;
  wire [7:0] wd, rdat;
  int err_count = 0, total_checks = 0;
  // 250 MHz system clock
  initial forever #2 clk = ~clk;
  urs_rx_status i_urs_rx_status (.CLK_SYS(clk), .SYS_RST(rst), .REG_ADDR(ra), .REG_WR(rw),
    .REG_RD(rr), .REG_WDATA(wd), .REG_RDATA(rdat), .CTS_N(cts_n), .RX_BIT_STROBE(bs),
    .RX_BIT_SAMPLES(smp), .RX_CHAR_VALID(cv), .RX_CHAR_DATA(cd), .RX_NINTH_BIT(n9),
    .RX_PARITY_BAD(pb), .RX_STOP_BAD(sb), .RX_BREAK(bk), .LINE_ERR_SUMMARY(les),
    .SPECIAL_SUMMARY(sps));
  urs_host_model i_urs_host_model (.clk(clk), .rst(rst), .addr(ra), .wr_en(rw), .rd_en(rr),
    .wdata(wd), .rd_done(done));
  // ---------------------------------------------
  // shared tasks
  // ---------------------------------------------
  task automatic check(input string nm, input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %s exp %h got %h", nm, e, s);
    end
  endtask : check
  task automatic close_out;
    if (err_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    i_urs_host_model.wr(a, v);
  endtask : wr
  // note the expected answer first, the monitor pairs it with the result
  task automatic rdx(input logic [3:0] a, input logic [7:0] e);
    q.push_back({a, e});
    i_urs_host_model.rd(a);
  endtask : rdx
  // one finished character; flags are {noise, break, stop, parity, ninth}
  task automatic rx(input logic [7:0] dv, input logic [4:0] f);
    @(posedge clk);
    {cv, bs, cd, smp} <= {2'b11, dv, f[4] ? 3'b010 : 3'b000};
    {bk, sb, pb, n9} <= f[3:0];
    @(posedge clk);
    {cv, bs} <= 2'b00;
  endtask : rx
  // receive, pop and look at the line status of that character
  task automatic pc(input logic [7:0] dv, input logic [4:0] f, input logic [7:0] ls);
    rx(dv, f);
    rdx(4'h0, f[3] ? 8'h00 : dv);
    rdx(4'h4, ls);
  endtask : pc
  // monitor: compare each read answer with the oldest note
  initial forever begin
    @(posedge clk);
    if (done === 1'b1) begin
      check($sformatf("reg %h", q[0][11:8]), rdat, q[0][7:0]);
      void'(q.pop_front());
    end
  end
  // watchdog: the whole sequence needs under five hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    close_out();
  end
  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial begin
    void'($urandom(45474));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (5) @(posedge clk);
    // reset values, then access kinds (read-only and unmapped writes ignored)
    for (int a = 1; a < 10; a++) if (a != 4) rdx(4'(a), 8'h00);
    for (int i = 0; i < 5; i++) wr(wa[i], 8'hff);
    for (int i = 0; i < 5; i++) rdx(wa[i], wx[i]);
    wr(4'h5, 8'h00);
    // each character flag with a random enable mask
    for (int k = 2; k < 6; k++) begin
      d = 8'($urandom);
      en = 8'($urandom);
      pc(d, 5'h0, 8'h80);
      rdx(4'h2, 8'h00);
      wr(4'h3, en);
      pc(d, 5'h1 << (k - 1), 8'h80 | (8'h1 << k));
      rdx(4'h4, 8'h80 | (8'h1 << k));
      #1 check("line summary", {7'h0, les}, {7'h0, en[k]});
      rdx(4'h2, {7'h0, en[k]});
    end
    // overrun: seventeenth character into a full fifo is dropped
    wr(4'h3, 8'h02);
    pc(d, 5'h0, 8'h80);
    for (int i = 0; i < 17; i++) begin
      ov[i] = 8'($urandom);
      rx(ov[i], 5'h0);
    end
    rdx(4'h4, 8'h82);
    rdx(4'h2, 8'h01);
    for (int i = 0; i < 16; i++) rdx(4'h0, ov[i]);
    // stale data after two units of sixteen cycles, zero disables
    wr(4'hb, 8'h02);
    wr(4'h3, 8'h01);
    rx(d, 5'h0);
    repeat (8) @(posedge clk);
    rdx(4'h4, 8'h80);
    repeat (40) @(posedge clk);
    rdx(4'h4, 8'h81);
    rdx(4'h2, 8'h01);
    rdx(4'h0, d);
    rdx(4'h4, 8'h80);
    wr(4'hb, 8'h00);
    rx(d, 5'h0);
    repeat (60) @(posedge clk);
    rdx(4'h4, 8'h80);
    rdx(4'h0, d);
    // special characters; the earlier break left its flag standing
    rdx(4'h6, 8'h10);
    rdx(4'h6, 8'h00);
    wr(4'h3, 8'h00);
    wr(4'ha, 8'h10);
    for (int i = 0; i < 4; i++) begin
      c[i] = {2'(i), 6'($urandom)};
      wr(4'(12 + i), c[i]);
    end
    for (int i = 0; i < 4; i++) begin
      wr(4'h5, 8'h1 << i);
      pc(c[i], 5'h0, 8'h80);
      #1 check("special summary", {7'h0, sps}, 8'h01);
      rdx(4'h2, 8'h02);
      rdx(4'h6, 8'h1 << i);
    end
    wr(4'h5, 8'h00);
    pc(c[0], 5'h0, 8'h80);
    rdx(4'h2, 8'h00);
    rdx(4'h6, 8'h01);
    wr(4'ha, 8'h00);
    pc(c[1], 5'h0, 8'h80);
    rdx(4'h6, 8'h00);
    // nine-bit mode: parity bit carries the ninth bit
    wr(4'ha, 8'h40);
    wr(4'h5, 8'h20);
    pc(d, 5'h01, 8'h84);
    rdx(4'h6, 8'h20);
    rdx(4'h2, 8'h02);
    pc(d, 5'h02, 8'h80);
    rdx(4'h6, 8'h00);
    // top status bit follows the clear-to-send pin
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      cts_n <= ~cts_n;
      repeat (6) @(posedge clk);
      rdx(4'h4, {cts_n, 7'h00});
    end
    repeat (3) @(posedge clk);
    // every noted read must have been answered and compared
    check("pending reads", 8'(q.size()), 8'h00);
    close_out();
  end
endmodule : urs_rx_status_tb
`default_nettype wire
